// file: hdl/routing_pkg.sv
// Constants and types for the resource routing configuration bank
package routing_pkg;
   localparam int APB_AW = 12;
   localparam int APB_DW = 32;
   localparam int NREG   = 8;
   localparam int N_IRQ  = 7;
   localparam int N_DMA  = 3;
   localparam int PIN_W  = 16;
   localparam int HA_W   = 10;

   // Register indexes; byte address is four times the index
   localparam logic [7:0] IDX_ALT   = 8'h22;
   localparam logic [7:0] IDX_LPT   = 8'h23;
   localparam logic [7:0] IDX_SER1  = 8'h24;
   localparam logic [7:0] IDX_SER2  = 8'h25;
   localparam logic [7:0] IDX_DMA   = 8'h26;
   localparam logic [7:0] IDX_IRQ1  = 8'h27;
   localparam logic [7:0] IDX_IRQ2  = 8'h28;
   localparam logic [7:0] IDX_MODE  = 8'h30;
   localparam logic [7:0] IDX_STRAP = 8'h40;

   // Slot order of the storage array
   localparam int S_ALT  = 0;
   localparam int S_LPT  = 1;
   localparam int S_SER1 = 2;
   localparam int S_SER2 = 3;
   localparam int S_DMA  = 4;
   localparam int S_IRQ1 = 5;
   localparam int S_IRQ2 = 6;
   localparam int S_MODE = 7;

   localparam logic [7:0] REG_IDX [NREG] = '{IDX_ALT, IDX_LPT, IDX_SER1,
      IDX_SER2, IDX_DMA, IDX_IRQ1, IDX_IRQ2, IDX_MODE};
   localparam logic [7:0] RST_VAL [NREG] = '{8'h01, 8'h00, 8'h00, 8'h00,
      8'h10, 8'h10, 8'h00, 8'h00};
   localparam logic [7:0] WMASK [NREG] = '{8'hFC, 8'hFF, 8'hFE, 8'hFE,
      8'hFF, 8'hFF, 8'hFF, 8'h03};
   localparam logic [7:0] ROVAL [NREG] = '{8'h01, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00};

   // Field codes
   localparam logic [3:0] ALT_LOW    = 4'h6;
   localparam logic [3:0] CODE_NONE  = 4'h0;
   localparam logic [3:0] IRQ_FIRST  = 4'h1;
   localparam logic [3:0] IRQ_LAST   = 4'h6;
   localparam logic [3:0] IRQ_H_CODE = 4'h8;
   localparam int         IRQ_H_POS  = 6;
   localparam logic [3:0] DMA_LAST   = 4'h3;
   localparam int         ISADEF_POS = 6;

   // Pin vector positions and idle level
   localparam int PIN_A10  = 10;
   localparam int PIN_CS   = 11;
   localparam int PIN_ACK  = 12;
   localparam int PIN_STR  = 15;
   localparam logic [PIN_W-1:0] PIN_IDLE = 16'h7800;

   typedef enum logic [1:0] {
      LPT_COMPAT = 2'h0,
      LPT_BIDIR  = 2'h1,
      LPT_EPP    = 2'h2,
      LPT_ECP    = 2'h3
   } lpt_mode_t;

   typedef enum logic [1:0] {
      ST_SYNC1 = 2'h0,
      ST_SYNC2 = 2'h1,
      ST_LOAD  = 2'h3,
      ST_DONE  = 2'h2
   } strap_state_t;
endpackage

// file: hdl/resource_routing_config.sv
// Base address, DMA and interrupt routing bank behind an APB slave
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module resource_routing_config #(
   parameter logic [7:0] ISA_ALT  = 8'hFD,
   parameter logic [7:0] ISA_LPT  = 8'hDE,
   parameter logic [7:0] ISA_SER1 = 8'hFE,
   parameter logic [7:0] ISA_SER2 = 8'hBE,
   parameter logic [3:0] ISA_FDMA = 4'h2,
   parameter logic [7:0] ISA_IRQ1 = 8'h67,
   parameter logic [7:0] ISA_IRQ2 = 8'h43
) (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [routing_pkg::APB_AW-1:0] paddr,
   input  wire logic [routing_pkg::APB_DW-1:0] pwdata,
   input  wire logic [3:0]                   pstrb,
   output var  logic [routing_pkg::APB_DW-1:0] prdata,
   output var  logic                         pready,
   output var  logic                         pslverr,
   input  wire logic [routing_pkg::HA_W-1:0] host_addr,
   input  wire logic                         host_addr_bit10,
   input  wire logic                         chip_select_n,
   input  wire logic                         dma_request_b_strap,
   input  wire logic [routing_pkg::N_DMA-1:0] dma_ack_n,
   input  wire logic                         fdc_irq,
   input  wire logic                         lpt_irq,
   input  wire logic                         ser1_irq,
   input  wire logic                         ser2_irq,
   input  wire logic                         fdc_drq,
   input  wire logic                         lpt_drq,
   output var  logic                         alt_drive_sel,
   output var  logic                         lpt_sel,
   output var  logic                         serial_port_one_sel,
   output var  logic                         serial_port_two_sel,
   output var  logic [routing_pkg::N_IRQ-1:0] irq_out,
   output var  logic [routing_pkg::N_IRQ-1:0] irq_oe_n,
   output var  logic [routing_pkg::N_DMA-1:0] drq_out,
   output var  logic [routing_pkg::N_DMA-1:0] drq_oe_n,
   output var  logic                         floppy_controller_dack,
   output var  logic                         lpt_dack
);
   import routing_pkg::*;

   // Decoders for register slots, base enables and routing codes; slot_of serves both read and write paths
   function automatic logic [3:0] slot_of(input logic [7:0] idx);
      slot_of = 4'hF;
      for (int k = 0; k < NREG; k++) begin
         if (REG_IDX[k] == idx) begin
            slot_of = 4'(k);
         end
      end
   endfunction

   function automatic logic base_on(input logic [7:0] base);
      base_on = base[7:6] != 2'h0;
   endfunction

   function automatic logic [N_IRQ-1:0] irq_line(input logic [3:0] c);
      irq_line = '0;
      if (c >= IRQ_FIRST && c <= IRQ_LAST) begin
         irq_line[3'(c - IRQ_FIRST)] = 1'b1;
      end else if (c == IRQ_H_CODE) begin
         irq_line[IRQ_H_POS] = 1'b1;
      end
   endfunction

   function automatic logic [N_DMA-1:0] dma_chan(input logic [3:0] c);
      dma_chan = '0;
      if (c != CODE_NONE && c <= DMA_LAST) begin
         dma_chan[2'(c - IRQ_FIRST)] = 1'b1;
      end
   endfunction

   // Pin synchroniser; first stage feeds the second only
   logic [PIN_W-1:0] pin_meta;
   logic [PIN_W-1:0] pin_sync;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= PIN_IDLE;
         pin_sync <= PIN_IDLE;
      end else begin
         pin_meta <= {dma_request_b_strap, dma_ack_n, chip_select_n,
                      host_addr_bit10, host_addr};
         pin_sync <= pin_meta;
      end
   end

   wire [HA_W-1:0]  addr_s  = pin_sync[HA_W-1:0];
   wire             a10_s   = pin_sync[PIN_A10];
   wire             cs_n_s  = pin_sync[PIN_CS];
   wire [N_DMA-1:0] ack_n_s = pin_sync[PIN_ACK +: N_DMA];
   wire             strap_s = pin_sync[PIN_STR];

   // Strap capture waits for the synchroniser to fill
   strap_state_t state;
   strap_state_t next_state;
   logic         isa_mode;
   always_comb begin
      next_state = state;
      unique case (state)
         ST_SYNC1: next_state = ST_SYNC2;
         ST_SYNC2: next_state = ST_LOAD;
         ST_LOAD:  next_state = ST_DONE;
         ST_DONE:  next_state = ST_DONE;
      endcase
   end

   wire strap_load = (state == ST_LOAD) & strap_s;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= ST_SYNC1;
         isa_mode <= 1'b0;
      end else begin
         state <= next_state;
         if (state == ST_LOAD) begin
            isa_mode <= strap_s;
         end
      end
   end

   // Bus decode
   wire [7:0] reg_idx   = paddr[9:2];
   wire       addr_ok   = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0;
   wire [3:0] slot      = slot_of(reg_idx);
   wire       is_strap  = addr_ok && reg_idx == IDX_STRAP;
   wire       mapped    = addr_ok && (slot != 4'hF || is_strap);
   wire       acc_write = psel & penable & pwrite & pstrb[0];
   wire       setup     = psel & ~penable;

   // ISA default image; parallel DMA field keeps its normal reset
   wire [7:0] isa_val [NREG];
   assign isa_val[S_ALT]  = ISA_ALT;
   assign isa_val[S_LPT]  = ISA_LPT;
   assign isa_val[S_SER1] = ISA_SER1;
   assign isa_val[S_SER2] = ISA_SER2;
   assign isa_val[S_DMA]  = {ISA_FDMA, RST_VAL[S_DMA][3:0]};
   assign isa_val[S_IRQ1] = ISA_IRQ1;
   assign isa_val[S_IRQ2] = ISA_IRQ2;
   assign isa_val[S_MODE] = RST_VAL[S_MODE];

   // Storage; read-only bits forced so they never hold a written value
   logic [7:0] cfg [NREG];
   for (genvar g = 0; g < NREG; g++) begin : g_reg
      wire       wr_hit   = acc_write && addr_ok && slot == 4'(g);
      wire [7:0] wr_value = (pwdata[7:0] & WMASK[g]) | ROVAL[g];
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cfg[g] <= RST_VAL[g];
         end else if (strap_load) begin
            cfg[g] <= (isa_val[g] & WMASK[g]) | ROVAL[g];
         end else if (wr_hit) begin
            cfg[g] <= wr_value;
         end
      end
   end

   wire [7:0] r_alt  = cfg[S_ALT];
   wire [7:0] r_lpt  = cfg[S_LPT];
   wire [7:0] r_s1   = cfg[S_SER1];
   wire [7:0] r_s2   = cfg[S_SER2];
   wire [7:0] r_dma  = cfg[S_DMA];
   wire [7:0] r_irq1 = cfg[S_IRQ1];
   wire [7:0] r_irq2 = cfg[S_IRQ2];
   wire [1:0] r_mode = cfg[S_MODE][1:0];

   // Read data; captured in setup so it is ready in the access phase
   wire [7:0] strap_byte = 8'(isa_mode) << ISADEF_POS;
   wire [7:0] rd_byte    = is_strap ? strap_byte
                         : (slot != 4'hF) ? cfg[3'(slot)] : 8'h00;
   wire [APB_DW-1:0] next_prdata = mapped ? APB_DW'(rd_byte) : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
         pready  <= 1'b1;
      end else begin
         pready <= 1'b1;
         if (setup) begin
            prdata  <= next_prdata;
            pslverr <= ~mapped;
         end
      end
   end

   // Function decoders on the synchronised host address
   wire lpt_epp  = r_mode == LPT_EPP;
   wire lpt_ecp  = r_mode == LPT_ECP;
   wire qual_std = ~cs_n_s & ~a10_s;

   wire hit_alt = base_on(r_alt) & qual_std
                & addr_s[9:4] == r_alt[7:2]
                & addr_s[3:0] == ALT_LOW;

   wire lpt_qual  = ~cs_n_s & (lpt_ecp | ~a10_s);
   wire lpt_match = lpt_epp ? addr_s[9:3] == r_lpt[7:1]
                            : addr_s[9:2] == r_lpt;
   wire hit_lpt   = base_on(r_lpt) & lpt_qual & lpt_match;

   wire hit_s1 = base_on(r_s1) & qual_std
               & addr_s[9:3] == r_s1[7:1];
   wire hit_s2 = base_on(r_s2) & qual_std
               & addr_s[9:3] == r_s2[7:1];

   // Interrupt routing; a line is driven only when someone selects it
   wire [N_IRQ-1:0] fdc_il = irq_line(r_irq1[7:4]);
   wire [N_IRQ-1:0] lpt_il = irq_line(r_irq1[3:0]);
   wire [N_IRQ-1:0] s1_il  = irq_line(r_irq2[7:4]);
   wire [N_IRQ-1:0] s2_il  = irq_line(r_irq2[3:0]);
   wire [N_IRQ-1:0] next_irq_out = (fdc_il & {N_IRQ{fdc_irq}})
                                 | (lpt_il & {N_IRQ{lpt_irq}})
                                 | (s1_il  & {N_IRQ{ser1_irq}})
                                 | (s2_il  & {N_IRQ{ser2_irq}});
   wire [N_IRQ-1:0] next_irq_oe_n = ~(fdc_il | lpt_il | s1_il | s2_il);

   // DMA routing; two users on one channel is a software error
   wire [N_DMA-1:0] fdc_ch = dma_chan(r_dma[7:4]);
   wire [N_DMA-1:0] lpt_ch = dma_chan(r_dma[3:0]);
   wire [N_DMA-1:0] next_drq_out = (fdc_ch & {N_DMA{fdc_drq}})
                                 | (lpt_ch & {N_DMA{lpt_drq}});
   wire [N_DMA-1:0] next_drq_oe_n = ~(fdc_ch | lpt_ch);
   wire next_fdc_dack = |(fdc_ch & ~ack_n_s);
   wire next_lpt_dack = |(lpt_ch & ~ack_n_s);

   // Output register stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alt_drive_sel       <= 1'b0;
         lpt_sel             <= 1'b0;
         serial_port_one_sel <= 1'b0;
         serial_port_two_sel <= 1'b0;
         irq_out             <= '0;
         irq_oe_n            <= '1;
         drq_out             <= '0;
         drq_oe_n            <= '1;
         floppy_controller_dack <= 1'b0;
         lpt_dack            <= 1'b0;
      end else begin
         alt_drive_sel       <= hit_alt;
         lpt_sel             <= hit_lpt;
         serial_port_one_sel <= hit_s1;
         serial_port_two_sel <= hit_s2;
         irq_out             <= next_irq_out;
         irq_oe_n            <= next_irq_oe_n;
         drq_out             <= next_drq_out;
         drq_oe_n            <= next_drq_oe_n;
         floppy_controller_dack <= next_fdc_dack;
         lpt_dack            <= next_lpt_dack;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   alt_ro_bits_a: assert property (
      r_alt[1:0] == ROVAL[S_ALT][1:0])
      else $error("alt drive reserved bits wrong");

   alt_decode_a: assert property (
      alt_drive_sel |-> $past(addr_s[9:4]) == $past(r_alt[7:2])
                     && $past(addr_s[3:0]) == ALT_LOW)
      else $error("alt drive select without base match");

   lpt_off_a: assert property (
      lpt_sel |-> $past(r_lpt[7:6]) != 2'h0)
      else $error("parallel select while decoder disabled");

   lpt_epp_a: assert property (
      lpt_sel && $past(lpt_epp) |-> $past(addr_s[9:3]) == $past(r_lpt[7:1]))
      else $error("parallel EPP select off its 8-byte block");

   lpt_spp_a: assert property (
      lpt_sel && !$past(lpt_epp) |-> $past(addr_s[9:2]) == $past(r_lpt))
      else $error("parallel select off its 4-byte block");

   lpt_qual_a: assert property (
      lpt_sel |-> !$past(cs_n_s) && (!$past(a10_s) || $past(lpt_ecp)))
      else $error("parallel select without qualification");

   ser1_sel_a: assert property (
      serial_port_one_sel |-> $past(addr_s[9:3]) == $past(r_s1[7:1])
         && $past(r_s1[7:6]) != 2'h0 && !$past(cs_n_s) && !$past(a10_s))
      else $error("serial one select without full match");

   ser2_sel_a: assert property (
      serial_port_two_sel |-> $past(addr_s[9:3]) == $past(r_s2[7:1])
         && $past(r_s2[7:6]) != 2'h0 && !$past(cs_n_s) && !$past(a10_s))
      else $error("serial two select without full match");

   ser_bit0_a: assert property (
      r_s1[0] == 1'b0 && r_s2[0] == 1'b0)
      else $error("serial base bit 0 not zero");

   fdc_irq_a: assert property (
      $past(presetn) && $past(r_irq1[7:4]) == IRQ_FIRST && $past(fdc_irq)
         |-> irq_out[0] && !irq_oe_n[0])
      else $error("floppy irq not on line A");

   ser_irq_h_a: assert property (
      $past(r_irq2[7:4]) == IRQ_H_CODE && $past(ser1_irq)
         |-> irq_out[IRQ_H_POS] && !irq_oe_n[IRQ_H_POS])
      else $error("serial one irq not on line H");

   irq_float_a: assert property (
      $past(r_irq1) == 8'h00 && $past(r_irq2) == 8'h00 |-> &irq_oe_n)
      else $error("irq line driven with no selection");

   dma_route_a: assert property (
      $past(r_dma[3:0]) == DMA_LAST && $past(lpt_drq)
         |-> drq_out[2] && !drq_oe_n[2])
      else $error("parallel DMA not on channel C");

   dma_float_a: assert property (
      $past(r_dma) == 8'h00 |-> &drq_oe_n)
      else $error("DMA line driven with no selection");

   strap_isa_a: assert property (
      strap_load |=> r_lpt == ISA_LPT && r_s1 == (ISA_SER1 & WMASK[S_SER1])
                  && r_dma[3:0] == RST_VAL[S_DMA][3:0] ##1 state == ST_DONE)
      else $error("ISA defaults not loaded from strap");

   strap_flag_a: assert property (
      state == ST_LOAD |=> isa_mode == $past(strap_s))
      else $error("strap level not captured");

   isa_cov: cover property (strap_load ##1 state == ST_DONE);
   ser1_cov: cover property (serial_port_one_sel);
   lpt_ecp_cov: cover property (lpt_sel && $past(lpt_ecp && a10_s));
   irq_cov: cover property (!irq_oe_n[IRQ_H_POS] && irq_out[IRQ_H_POS]);
endmodule
`default_nettype wire

// file: verif/isa_host_model.sv
// Host bus and DMA controller model that drives the decoder pins
`timescale 1ns/10ps
`default_nettype none
module isa_host_model (
   input  wire logic                          pclk,
   output var  logic [routing_pkg::HA_W-1:0]  host_addr,
   output var  logic                          host_addr_bit10,
   output var  logic                          chip_select_n,
   output var  logic [routing_pkg::N_DMA-1:0] dma_ack_n
);
   import routing_pkg::*;

   // Idle bus: nothing selected, no acknowledge
   initial begin
      host_addr = 10'h155;
      host_addr_bit10 = 1'b1;
      chip_select_n = 1'b1;
      dma_ack_n = 3'h7;
   end

   // One host cycle, launched after an edge and held until the next
   task automatic cycle(input logic [9:0] a, input logic a10,
                        input logic cs_n);
      @(posedge pclk);
      host_addr <= a;
      host_addr_bit10 <= a10;
      chip_select_n <= cs_n;
   endtask

   // Released bus wanders so a stale address never looks valid
   task automatic release_bus;
      @(posedge pclk);
      chip_select_n <= 1'b1;
      host_addr <= ~host_addr;
   endtask

   // Acknowledge after a prompt or slow delay, active low
   task automatic ack(input logic [2:0] n, input int dly);
      repeat (dly + 1) @(posedge pclk);
      dma_ack_n <= n;
   endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the resource routing configuration bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import routing_pkg::*;
   logic              pclk, presetn, psel, penable, pwrite, strap;
   logic [APB_AW-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic [3:0]        pstrb;
   logic              pready, pslverr, er;
   logic              fdc_irq, lpt_irq, ser1_irq, ser2_irq, fdc_drq, lpt_drq;
   wire logic [9:0]   host_addr;
   wire logic         host_addr_bit10, chip_select_n;
   wire logic [2:0]   dma_ack_n;
   wire logic [3:0]   sel;
   logic [6:0]        irq_out, irq_oe_n;
   logic [2:0]        drq_out, drq_oe_n;
   logic              fdack, ldack;
   int fail_count = 0;
   int n_compared = 0;
   int m[NREG];
   const int wm[NREG] = '{8'hFC, 8'hFF, 8'hFE, 8'hFE, 8'hFF, 8'hFF, 8'hFF, 8'h03};
   const int ro[NREG] = '{8'h01, 0, 0, 0, 0, 0, 0, 0};
   const int rv[NREG] = '{8'h01, 0, 0, 0, 8'h10, 8'h10, 0, 0};
   const int iv[NREG] = '{8'hFD, 8'hDE, 8'hFE, 8'hBE, 8'h20, 8'h67, 8'h43, 0};

   // Strap images left at their defaults, which iv mirrors
   resource_routing_config i_resource_routing_config (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .host_addr, .host_addr_bit10,
      .chip_select_n, .dma_request_b_strap(strap), .dma_ack_n, .fdc_irq,
      .lpt_irq, .ser1_irq, .ser2_irq, .fdc_drq, .lpt_drq,
      .alt_drive_sel(sel[0]), .lpt_sel(sel[1]),
      .serial_port_one_sel(sel[2]), .serial_port_two_sel(sel[3]),
      .irq_out, .irq_oe_n, .drq_out, .drq_oe_n,
      .floppy_controller_dack(fdack), .lpt_dack(ldack));

   isa_host_model i_isa_host_model (.pclk, .host_addr, .host_addr_bit10,
      .chip_select_n, .dma_ack_n);

   // 10 MHz clock
   always begin
      #50 pclk = ~pclk;
   end

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer; waits for pready under a bounded count
   task automatic apb(bit wr, logic [7:0] idx, logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready", 1, n < 50);
   endtask

   // Writes keep the model in step; read-only bits stay fixed
   task automatic wr(int s, logic [7:0] d);
      apb(1'b1, REG_IDX[s], d);
      m[s] = (d & wm[s]) | ro[s];
   endtask

   task automatic rd_all;
      for (int s = 0; s < NREG; s++) begin
         apb(1'b0, REG_IDX[s], 8'h00);
         chk($sformatf("reg%0d", s), m[s], rd);
         chk("mapped err", 0, er);
      end
   endtask

   // Reset with the strap held stable until after its sample edge
   task automatic do_reset(bit s);
      presetn <= 1'b0;
      strap <= s;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      for (int i = 0; i < NREG; i++) m[i] = s ? iv[i] : rv[i];
      rd_all();
      apb(1'b0, IDX_STRAP, 8'h00);
      chk("strap status", s ? 32'h40 : 0, rd);
   endtask

   function automatic logic [3:0] exp_sel(int a, bit a10, bit cs);
      bit q;
      int md;
      q = !cs && !a10;
      md = m[S_MODE] & 3;
      exp_sel[0] = q && m[S_ALT][7:6] != 0 && a[9:4] == m[S_ALT][7:2]
                   && a[3:0] == 6;
      exp_sel[1] = !cs && (md == 3 || !a10) && m[S_LPT][7:6] != 0
                   && (md == 2 ? a[9:3] == m[S_LPT][7:1]
                               : a[9:2] == m[S_LPT][7:0]);
      exp_sel[2] = q && m[S_SER1][7:6] != 0 && a[9:3] == m[S_SER1][7:1];
      exp_sel[3] = q && m[S_SER2][7:6] != 0 && a[9:3] == m[S_SER2][7:1];
   endfunction

   // One-hot line for an interrupt or DMA code; reserved codes route nowhere
   // Fields are four bits wide, so codes wrap as the register stores them
   function automatic int line(int c, bit dma);
      if (c[3:0] >= 1 && c[3:0] <= (dma ? 3 : 6)) return 1 << (c[3:0] - 1);
      return (!dma && c[3:0] == 8) ? 32'h40 : 0;
   endfunction

   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      #2000000;
      fail_count++;
      summarize();
   end

   initial begin
      int a, f, r, k, o, dk;
      {pclk, psel, penable, pwrite, paddr, pwdata, presetn, strap} = '0;
      {fdc_irq, lpt_irq, ser1_irq, ser2_irq, fdc_drq, lpt_drq} = '0;
      pstrb = 4'hF;
      void'($urandom(84));
      do_reset(1'b0);
      $display("test reset defaults done");
      for (int s = 0; s < NREG; s++) wr(s, $urandom);
      rd_all();
      apb(1'b0, 8'h29, 8'h00);
      chk("unmapped err", 1, er);
      chk("unmapped data", 0, rd);
      // Byte lane zero off: the write must not land
      pstrb <= 4'h0;
      apb(1'b1, REG_IDX[S_LPT], ~m[S_LPT][7:0]);
      pstrb <= 4'hF;
      apb(1'b0, REG_IDX[S_LPT], 8'h00);
      chk("strobe off", m[S_LPT], rd);
      $display("test register access done");
      for (int i = 0; i < 80; i++) begin
         for (int s = S_ALT; s <= S_SER2; s++) wr(s, $urandom);
         wr(S_MODE, $urandom);
         f = $urandom % 4;
         a = $urandom;
         if (f == 0) a = {m[S_ALT][7:2], 4'h6};
         if (f == 1) a = {m[S_LPT][7:0], a[1:0]};
         if (f >= 2) a = {m[f][7:1], a[2:0]};
         if ($urandom % 4 == 0) a = a ^ (1 << ($urandom % 10));
         k = ($urandom % 4 == 0);
         o = ($urandom % 4 == 0);
         i_isa_host_model.cycle(a[9:0], k[0], o[0]);
         repeat (3) @(posedge pclk);
         #1 chk("selects", exp_sel(a, k, o), sel);
         i_isa_host_model.release_bus();
      end
      $display("test host decode done");
      for (int c = 0; c < 16; c++) begin
         wr(S_IRQ1, {c[3:0], 4'(c + 1)});
         wr(S_IRQ2, {4'(c + 2), 4'(c + 3)});
         r = $urandom;
         @(posedge pclk);
         {fdc_irq, lpt_irq, ser1_irq, ser2_irq} <= r[3:0];
         @(posedge pclk);
         o = line(c, 0) | line(c + 1, 0) | line(c + 2, 0) | line(c + 3, 0);
         k = (r[3] ? line(c, 0) : 0) | (r[2] ? line(c + 1, 0) : 0)
           | (r[1] ? line(c + 2, 0) : 0) | (r[0] ? line(c + 3, 0) : 0);
         #1 chk("irq_oe_n", ~o & 7'h7F, irq_oe_n);
         chk("irq_out", k, irq_out);
      end
      $display("test interrupt routing done");
      for (int c = 0; c < 16; c++) begin
         wr(S_DMA, {c[3:0], 4'(c + 1)});
         r = $urandom;
         i_isa_host_model.ack(r[2:0], r[5:4]);
         {fdc_drq, lpt_drq} <= r[7:6];
         repeat (3) @(posedge pclk);
         o = line(c, 1) | line(c + 1, 1);
         k = (r[7] ? line(c, 1) : 0) | (r[6] ? line(c + 1, 1) : 0);
         dk = ~r[2:0];
         #1 chk("drq_oe_n", ~o & 3'h7, drq_oe_n);
         chk("drq_out", k, drq_out);
         chk("fdc dack", (line(c, 1) & dk) != 0, fdack);
         chk("lpt dack", (line(c + 1, 1) & dk) != 0, ldack);
      end
      $display("test dma routing done");
      do_reset(1'b1);
      $display("test strap defaults done");
      summarize();
   end
endmodule
`default_nettype wire
